// ===== rtl/yrw_map.svh
`ifndef YRW_MAP_SVH
`define YRW_MAP_SVH
// ====================================================================
// register indexes (byte address is four times the index)
`define YRW_IDX_MODE 12'h0240
`define YRW_IDX_S0_LO 12'h0242
`define YRW_IDX_S0_HI 12'h0244
`define YRW_IDX_S1_LO 12'h0246
`define YRW_IDX_S1_HI 12'h0248
`define YRW_IDX_UVFIX 12'h024A
`define YRW_IDX_RECT_W 12'h024C
`define YRW_IDX_LINE_OFF 12'h024E
`define YRW_IDX_STATUS 12'h0250
// ====================================================================
// write masks and reset values
`define YRW_MODE_MASK 16'h3077
`define YRW_MODE_RST 16'h0005
`define YRW_HI_MASK 16'h0003
`define YRW_RECT_W_MASK 16'h07FF
`define YRW_LINE_OFF_MASK 16'h0FFF
`define YRW_ZERO16 16'h0000
// ====================================================================
// mode field positions
`define YRW_B_FIX_HI 13
`define YRW_B_FIX_LO 12
`define YRW_B_RECT 6
`define YRW_B_DBL 5
`define YRW_B_ITYPE 4
// ====================================================================
// data path constants
`define YRW_FIFO_DEPTH 16
`define YRW_WORD_STEP 19'h0_0004
`define YRW_CHROMA_ZERO 20'sh0_0080
`define YRW_STUDIO_BLACK 20'sh0_0010
`define YRW_STUDIO_Y_GAIN 20'sh0_012A
`define YRW_STUDIO_C_GAIN 20'sh0_0124
`endif

// ===== rtl/yrw_pkg.sv
package yrw_pkg;
  // buffer region that the current frame goes to
  typedef enum logic {YRW_BUF_ZERO, YRW_BUF_ONE} yrw_buf_t;
  // Q8 conversion coefficients: r from v, g from u, g from v, b from u
  typedef struct packed {
    logic [9:0] rv;
    logic [9:0] gu;
    logic [9:0] gv;
    logic [9:0] bu;
  } yrw_coef_t;
  // coefficient set for each transfer mode; reserved codes use the default set
  function automatic yrw_coef_t yrw_coef_sel(input logic [2:0] mode);
    yrw_coef_t c;
    c = '{rv: 10'h167, gu: 10'h058, gv: 10'h0B7, bu: 10'h1C6};
    case (mode)
      3'h1: c = '{rv: 10'h193, gu: 10'h030, gv: 10'h078, bu: 10'h1DB};
      3'h7: c = '{rv: 10'h193, gu: 10'h03A, gv: 10'h07A, bu: 10'h1D3};
      default: c = '{rv: 10'h167, gu: 10'h058, gv: 10'h0B7, bu: 10'h1C6};
    endcase
    return c;
  endfunction
endpackage

// ===== rtl/yrw_top.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "yrw_map.svh"

// ====================================================================
// fifo between the pixel packer and the frame buffer port
module yrw_fifo #(
  parameter int W = 33,
  parameter int D = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_reg, rd_ptr_reg;
  logic push, pop;

  // full and empty from pointer difference
  assign level_o = wr_ptr_reg - rd_ptr_reg;
  assign in_ready_o = (level_o != (AW+1)'(D));
  assign out_valid_o = (level_o != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

  // storage
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end

  // pointers
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule

// ====================================================================
// colour space converter and frame buffer writer
module yrw_top (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic pix_sof_i,
  input wire logic [7:0] pix_y_i,
  input wire logic [7:0] pix_u_i,
  input wire logic [7:0] pix_v_i,
  output logic fb_valid_o,
  input wire logic fb_ready_i,
  output logic [18:0] fb_addr_o,
  output logic [31:0] fb_data_o,
  output yrw_pkg::yrw_buf_t fb_region_o
);
  import yrw_pkg::*;

  // ==================================================================
  // register bus
  logic [15:0] mode_reg, s0_lo_reg, s0_hi_reg, s1_lo_reg, s1_hi_reg;
  logic [15:0] uvfix_reg, rect_w_reg, line_off_reg;
  logic [11:0] idx;
  logic wr_en, hit_mode, hit_s0l, hit_s0h, hit_s1l, hit_s1h, hit_uv, hit_rw, hit_lo, hit_st;
  logic mapped;
  logic [15:0] rd_mux, status_val;
  logic [4:0] fifo_level;

  // address decode
  assign idx = paddr_i[13:2];
  assign hit_mode = (idx == `YRW_IDX_MODE);
  assign hit_s0l = (idx == `YRW_IDX_S0_LO);
  assign hit_s0h = (idx == `YRW_IDX_S0_HI);
  assign hit_s1l = (idx == `YRW_IDX_S1_LO);
  assign hit_s1h = (idx == `YRW_IDX_S1_HI);
  assign hit_uv = (idx == `YRW_IDX_UVFIX);
  assign hit_rw = (idx == `YRW_IDX_RECT_W);
  assign hit_lo = (idx == `YRW_IDX_LINE_OFF);
  assign hit_st = (idx == `YRW_IDX_STATUS);
  assign mapped = hit_mode | hit_s0l | hit_s0h | hit_s1l | hit_s1h | hit_uv | hit_rw
                  | hit_lo | hit_st;
  assign wr_en = psel_i && penable_i && pwrite_i && mapped;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // read selection; status is read-only
  assign rd_mux = hit_mode ? mode_reg :
                  hit_s0l ? s0_lo_reg :
                  hit_s0h ? s0_hi_reg :
                  hit_s1l ? s1_lo_reg :
                  hit_s1h ? s1_hi_reg :
                  hit_uv ? uvfix_reg :
                  hit_rw ? rect_w_reg :
                  hit_lo ? line_off_reg :
                  hit_st ? status_val : `YRW_ZERO16;
  assign prdata_o = {16'h0000, rd_mux};

  // register writes; masks keep reserved and absent bits at zero
  // reserved bit masked
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_reg <= `YRW_MODE_RST;
      s0_lo_reg <= `YRW_ZERO16;
      s0_hi_reg <= `YRW_ZERO16;
      s1_lo_reg <= `YRW_ZERO16;
      s1_hi_reg <= `YRW_ZERO16;
      uvfix_reg <= `YRW_ZERO16;
      rect_w_reg <= `YRW_ZERO16;
      line_off_reg <= `YRW_ZERO16;
    end
    else if (wr_en)
    begin
      if (hit_mode) mode_reg <= pwdata_i[15:0] & `YRW_MODE_MASK;
      if (hit_s0l) s0_lo_reg <= pwdata_i[15:0];
      if (hit_s0h) s0_hi_reg <= pwdata_i[15:0] & `YRW_HI_MASK;
      if (hit_s1l) s1_lo_reg <= pwdata_i[15:0];
      if (hit_s1h) s1_hi_reg <= pwdata_i[15:0] & `YRW_HI_MASK;
      if (hit_uv) uvfix_reg <= pwdata_i[15:0];
      if (hit_rw) rect_w_reg <= pwdata_i[15:0] & `YRW_RECT_W_MASK;
      if (hit_lo) line_off_reg <= pwdata_i[15:0] & `YRW_LINE_OFF_MASK;
    end
  end

  // ==================================================================
  // conversion
  logic [1:0] fix_sel;
  logic [7:0] u_in, v_in;
  logic signed [19:0] y_s, u_s, v_s, r_s, g_s, b_s;
  yrw_coef_t coef;
  logic [15:0] pix565;

  function automatic logic [7:0] clamp8(input logic signed [19:0] x);
    if (x < 20'sd0) return 8'h00;
    if (x > 20'sd255) return 8'hFF;
    return x[7:0];
  endfunction

  // fixed U when select is 01b or 11b
  // fixed V when select is 10b or 11b
  assign fix_sel = mode_reg[`YRW_B_FIX_HI:`YRW_B_FIX_LO];
  assign u_in = fix_sel[0] ? uvfix_reg[15:8] : pix_u_i;
  assign v_in = fix_sel[1] ? uvfix_reg[7:0] : pix_v_i;
  assign coef = yrw_coef_sel(mode_reg[2:0]);

  // full range or studio range input
  always_comb
  begin
    y_s = $signed({12'h000, pix_y_i});
    u_s = $signed({12'h000, u_in}) - `YRW_CHROMA_ZERO;
    v_s = $signed({12'h000, v_in}) - `YRW_CHROMA_ZERO;
    if (mode_reg[`YRW_B_ITYPE])
    begin
      y_s = ((y_s - `YRW_STUDIO_BLACK) * `YRW_STUDIO_Y_GAIN) >>> 8;
      u_s = (u_s * `YRW_STUDIO_C_GAIN) >>> 8;
      v_s = (v_s * `YRW_STUDIO_C_GAIN) >>> 8;
    end
    r_s = y_s + ((v_s * $signed({10'h000, coef.rv})) >>> 8);
    g_s = y_s - ((u_s * $signed({10'h000, coef.gu})) >>> 8)
              - ((v_s * $signed({10'h000, coef.gv})) >>> 8);
    b_s = y_s + ((u_s * $signed({10'h000, coef.bu})) >>> 8);
  end

  logic [7:0] r8, g8, b8;
  assign r8 = clamp8(r_s);
  assign g8 = clamp8(g_s);
  assign b8 = clamp8(b_s);
  assign pix565 = {r8[7:3], g8[7:2], b8[7:3]};

  // ==================================================================
  // pixel pairing into 32-bit words; a new frame restarts the pair
  logic half_reg, half_next, pair_sof_reg, pair_sof_next;
  logic [15:0] low_pix_reg, low_pix_next;
  logic pix_fire, push, fifo_in_ready;
  logic [32:0] push_word;

  assign pix_ready_o = !half_reg || fifo_in_ready;
  assign pix_fire = pix_valid_i && pix_ready_o;
  assign push = pix_fire && half_reg && !pix_sof_i;
  assign push_word = {pair_sof_reg, pix565, low_pix_reg};
  assign half_next = pix_fire ? !(half_reg && !pix_sof_i) : half_reg;
  assign pair_sof_next = (pix_fire && (!half_reg || pix_sof_i)) ? pix_sof_i : pair_sof_reg;
  assign low_pix_next = (pix_fire && (!half_reg || pix_sof_i)) ? pix565 : low_pix_reg;

  // pair holding registers
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      half_reg <= 1'b0;
      pair_sof_reg <= 1'b0;
      low_pix_reg <= 16'h0000;
    end
    else
    begin
      half_reg <= half_next;
      pair_sof_reg <= pair_sof_next;
      low_pix_reg <= low_pix_next;
    end
  end

  logic fifo_out_valid, fifo_out_ready;
  logic [32:0] fifo_out_data;

  yrw_fifo #(.W(33), .D(`YRW_FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  // ==================================================================
  // address generation and frame buffer port
  logic pop, sof_pop, word_pop;
  logic cur_rect_reg, cur_rect_next, dbl_reg, dbl_next;
  yrw_buf_t buf_reg, buf_next;
  logic [9:0] wpl_reg, wpl_next, wcount_reg, wcount_next;
  logic [18:0] step_reg, step_next, line_reg, line_next, addr_next;
  logic [18:0] start0, start1, base;
  logic line_end;

  // start zero from upper low field over lower register
  // start one from its own register pair
  assign start0 = {1'b0, s0_hi_reg[1:0], s0_lo_reg[15:2], 2'b00};
  assign start1 = {1'b0, s1_hi_reg[1:0], s1_lo_reg[15:2], 2'b00};

  assign fifo_out_ready = !fb_valid_o || fb_ready_i;
  assign pop = fifo_out_valid && fifo_out_ready;
  assign sof_pop = pop && fifo_out_data[32];
  assign word_pop = pop && !fifo_out_data[32];

  // mode captured at frame start only
  // rectangular placement honoured only with single buffering
  assign dbl_next = sof_pop ? mode_reg[`YRW_B_DBL] : dbl_reg;
  assign cur_rect_next = sof_pop ? (mode_reg[`YRW_B_RECT] && !mode_reg[`YRW_B_DBL])
                                 : cur_rect_reg;
  assign wpl_next = sof_pop ? rect_w_reg[10:1] : wpl_reg;
  assign step_next = sof_pop ? {6'h00, line_off_reg[11:1], 2'b00} : step_reg;

  // single buffering stays in region zero
  assign buf_next = !sof_pop ? buf_reg :
                    !mode_reg[`YRW_B_DBL] ? YRW_BUF_ZERO :
                    (buf_reg == YRW_BUF_ZERO) ? YRW_BUF_ONE : YRW_BUF_ZERO;
  assign base = (buf_next == YRW_BUF_ONE) ? start1 : start0;

  assign line_end = (wcount_reg >= wpl_reg);
  // rectangular step to next line start
  assign addr_next = sof_pop ? base :
                     (cur_rect_reg && line_end) ? line_reg + step_reg :
                     fb_addr_o + `YRW_WORD_STEP;
  assign line_next = sof_pop ? base :
                     (word_pop && cur_rect_reg && line_end) ? line_reg + step_reg : line_reg;
  assign wcount_next = sof_pop ? 10'h001 :
                       !word_pop ? wcount_reg :
                       line_end ? 10'h001 : wcount_reg + 10'h001;

  // frame state
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dbl_reg <= 1'b0;
      cur_rect_reg <= 1'b0;
      buf_reg <= YRW_BUF_ZERO;
      wpl_reg <= 10'h000;
      step_reg <= 19'h0_0000;
      line_reg <= 19'h0_0000;
      wcount_reg <= 10'h000;
    end
    else
    begin
      dbl_reg <= dbl_next;
      cur_rect_reg <= cur_rect_next;
      buf_reg <= buf_next;
      wpl_reg <= wpl_next;
      step_reg <= step_next;
      line_reg <= line_next;
      wcount_reg <= wcount_next;
    end
  end

  // output word register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fb_valid_o <= 1'b0;
      fb_addr_o <= 19'h0_0000;
      fb_data_o <= 32'h0000_0000;
    end
    else if (fifo_out_ready)
    begin
      fb_valid_o <= fifo_out_valid;
      if (pop)
      begin
        fb_addr_o <= addr_next;
        fb_data_o <= fifo_out_data[31:0];
      end
    end
  end

  assign fb_region_o = buf_reg;
  // status: region, rectangular active, double active, fifo level
  assign status_val = {8'h00, fifo_level, dbl_reg, cur_rect_reg, buf_reg};

  // ==================================================================
  // checks
  // continuous step
  property p_cont_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
      word_pop && !cur_rect_reg |=> fb_addr_o == $past(fb_addr_o) + `YRW_WORD_STEP;
  endproperty
  a_cont_step: assert property (p_cont_step) else $error("continuous step wrong");

  property p_rect_wrap;
    @(posedge mclk_i) disable iff (!reset_n_i)
      word_pop && cur_rect_reg && line_end |=> fb_addr_o == $past(line_reg + step_reg);
  endproperty
  a_rect_wrap: assert property (p_rect_wrap) else $error("line wrap wrong");

  property p_single_start;
    @(posedge mclk_i) disable iff (!reset_n_i)
      sof_pop && !mode_reg[`YRW_B_DBL] |=> fb_addr_o == $past(start0) && buf_reg == YRW_BUF_ZERO;
  endproperty
  a_single_start: assert property (p_single_start) else $error("single start wrong");

  property p_dbl_alt;
    @(posedge mclk_i) disable iff (!reset_n_i)
      sof_pop && mode_reg[`YRW_B_DBL] |=> buf_reg != $past(buf_reg);
  endproperty
  a_dbl_alt: assert property (p_dbl_alt) else $error("no alternation");

  property p_buf_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !sof_pop |=> $stable(buf_reg);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("region changed mid frame");

  property p_mode_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !sof_pop |=> $stable(cur_rect_reg) && $stable(dbl_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid frame");

  property p_align;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fb_valid_o |-> fb_addr_o[1:0] == 2'b00;
  endproperty
  a_align: assert property (p_align) else $error("unaligned write");

  property p_fix_u;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fix_sel[0] |-> u_in == uvfix_reg[15:8];
  endproperty
  a_fix_u: assert property (p_fix_u) else $error("U not fixed");

  property p_fix_v;
    @(posedge mclk_i) disable iff (!reset_n_i)
      fix_sel[1] |-> v_in == uvfix_reg[7:0];
  endproperty
  a_fix_v: assert property (p_fix_v) else $error("V not fixed");

  property p_resv_zero;
    @(posedge mclk_i) disable iff (!reset_n_i)
      psel_i && (hit_s0h || hit_s1h) |-> prdata_o[2] == 1'b0;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit set");

  c_dbl_frame: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    sof_pop && mode_reg[`YRW_B_DBL]);
  c_rect_wrap: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    word_pop && cur_rect_reg && line_end);
  c_fifo_full: cover property (@(posedge mclk_i) disable iff (!reset_n_i) !fifo_in_ready);
endmodule

// ===== verification/yrw_fb_model.sv
`timescale 1ns/1ps
// ====================================================================
// frame buffer memory model, logs every accepted word
module yrw_fb_model (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic fb_valid_i,
  input wire logic [18:0] fb_addr_i,
  input wire logic [31:0] fb_data_i,
  input wire yrw_pkg::yrw_buf_t fb_region_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic fb_ready_o
);
  import yrw_pkg::*;
  logic phase_reg;
  logic [18:0] addr_q[$];
  logic [31:0] data_q[$];
  yrw_buf_t reg_q[$];
  int bad = 0;
  // ready: held low on stall, every other cycle when slow
  assign fb_ready_o = !stall_i && (!slow_i || phase_reg);
  // alternating phase for slow answers
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_reg <= 1'b0;
    else
      phase_reg <= ~phase_reg;
  end
  always @(posedge mclk_i)
  begin
    if (reset_n_i && fb_valid_i && fb_ready_o)
    begin
      addr_q.push_back(fb_addr_i);
      data_q.push_back(fb_data_i);
      reg_q.push_back(fb_region_i);
      if (fb_addr_i[1:0] !== 2'b00)
        bad++;
    end
  end
endmodule

// ===== verification/yrw_top_bench.sv
`timescale 1ns/1ps
`include "yrw_map.svh"
`define TB_CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ====================================================================
// bench for the converter and frame buffer writer
module yrw_top_bench;
  import yrw_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pix_v = 1'b0, sof = 1'b0;
  logic stall = 1'b0, slow = 1'b0, pready, pslverr, pix_rdy, fbv, fbr, er, acc;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, fbd;
  logic [7:0] py = 8'h00, pu = 8'h00, pv = 8'h00;
  logic [18:0] fba;
  yrw_buf_t fbreg;
  int err_total = 0, checks = 0, n;
  // clock 125 MHz
  always #4 mclk_i = ~mclk_i;
  yrw_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pix_valid_i(pix_v), .pix_ready_o(pix_rdy),
    .pix_sof_i(sof), .pix_y_i(py), .pix_u_i(pu), .pix_v_i(pv), .fb_valid_o(fbv),
    .fb_ready_i(fbr), .fb_addr_o(fba), .fb_data_o(fbd), .fb_region_o(fbreg));
  yrw_fb_model fbm (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .fb_valid_i(fbv),
    .fb_addr_i(fba), .fb_data_i(fbd), .fb_region_i(fbreg), .stall_i(stall),
    .slow_i(slow), .fb_ready_o(fbr));
  // ====================================================================
  // apb cycle, held until pready is seen high
  task apb(input logic w, input logic [11:0] idx, input logic [15:0] wd);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge mclk_i);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do
      @(posedge mclk_i);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    `TB_CHK(rd, {16'h0000, exp})
  endtask
  // one pixel, held until taken; caller stands just after a rising edge
  task px(input logic s, input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
    pix_v <= 1'b1;
    sof <= s;
    py <= y;
    pu <= u;
    pv <= v;
    // pixel stands until ready is seen high at a rising edge
    do
      @(posedge mclk_i);
    while (pix_rdy !== 1'b1);
  endtask
  task frame(input int np, input logic [7:0] y, input logic [7:0] u, input logic [7:0] v,
    input int du, input int dv);
    for (int i = 0; i < np; i++)
      px(i == 0, y, 8'(u + i * du), 8'(v + i * dv));
    pix_v <= 1'b0;
  endtask
  // wait for words, then check count
  task drain(input int nw);
    int k;
    k = 0;
    while (fbm.addr_q.size() < nw && k < 400)
    begin
      @(posedge mclk_i);
      k++;
    end
    repeat (4) @(posedge mclk_i);
    `TB_CHK(fbm.addr_q.size(), nw)
  endtask
  task clr;
    fbm.addr_q.delete();
    fbm.data_q.delete();
    fbm.reg_q.delete();
  endtask
  // expected word addresses for lines of lw words stepped by step bytes
  task addrs(input logic [18:0] st, input int nw, input int lw, input logic [18:0] step,
    input yrw_buf_t r);
    for (int i = 0; i < nw; i++)
    begin
      `TB_CHK(fbm.addr_q[i], 19'(st + (i / lw) * step + (i % lw) * 4))
      `TB_CHK(fbm.reg_q[i], r)
    end
    clr();
  endtask
  task one(input logic [15:0] m, input logic [7:0] y, input logic [31:0] exp);
    apb(1'b1, `YRW_IDX_MODE, m);
    frame(2, y, 8'h80, 8'h80, 0, 0);
    drain(1);
    `TB_CHK(fbm.data_q[0], exp)
    clr();
  endtask
  // ====================================================================
  // verdict
  task results;
    $display("counts: checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (30000) @(posedge mclk_i);
    err_total++;
    results();
  end
  // ====================================================================
  // tests
  initial
  begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rchk(`YRW_IDX_MODE, 16'h0005);
    rchk(`YRW_IDX_S0_LO, 16'h0000);
    rchk(`YRW_IDX_S0_HI, 16'h0000);
    rchk(`YRW_IDX_S1_LO, 16'h0000);
    rchk(`YRW_IDX_S1_HI, 16'h0000);
    rchk(`YRW_IDX_UVFIX, 16'h0000);
    apb(1'b0, 12'h0300, 16'h0000);
    `TB_CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1'b1, `YRW_IDX_S0_HI, 16'hFFFF);
    rchk(`YRW_IDX_S0_HI, 16'h0003);
    apb(1'b1, `YRW_IDX_UVFIX, 16'hA55A);
    rchk(`YRW_IDX_UVFIX, 16'hA55A);
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, `YRW_IDX_MODE, 16'(m));
      rchk(`YRW_IDX_MODE, 16'(m));
    end
    $display("test registers done");
    apb(1'b1, `YRW_IDX_S0_LO, 16'h0100);
    apb(1'b1, `YRW_IDX_S0_HI, 16'h0001);
    apb(1'b1, `YRW_IDX_MODE, 16'h0005);
    for (int f = 0; f < 2; f++)
    begin
      slow <= f[0];
      frame(8, 8'h40, 8'h80, 8'h80, 0, 0);
      drain(4);
      addrs(19'h1_0100, 4, 4, 19'h0_0000, YRW_BUF_ZERO);
    end
    $display("test single done");
    apb(1'b1, `YRW_IDX_S1_LO, 16'h0200);
    apb(1'b1, `YRW_IDX_S1_HI, 16'h0002);
    apb(1'b1, `YRW_IDX_MODE, 16'h0025);
    for (int f = 0; f < 3; f++)
    begin
      frame(4, 8'h40, 8'h80, 8'h80, 0, 0);
      drain(2);
      addrs((f % 2 == 0) ? 19'h2_0200 : 19'h1_0100, 2, 2, 19'h0_0000,
        (f % 2 == 0) ? YRW_BUF_ONE : YRW_BUF_ZERO);
    end
    $display("test double done");
    apb(1'b1, `YRW_IDX_RECT_W, 16'h0004);
    apb(1'b1, `YRW_IDX_LINE_OFF, 16'h0008);
    apb(1'b1, `YRW_IDX_MODE, 16'h0045);
    frame(8, 8'h40, 8'h80, 8'h80, 0, 0);
    drain(4);
    addrs(19'h1_0100, 4, 2, 19'h0_0010, YRW_BUF_ZERO);
    $display("test rectangle done");
    one(16'h0005, 8'h00, 32'h0000_0000);
    one(16'h0005, 8'hFF, 32'hFFFF_FFFF);
    one(16'h0005, 8'h10, 32'h1082_1082);
    one(16'h0015, 8'h10, 32'h0000_0000);
    one(16'h0015, 8'hEB, 32'hFFFF_FFFF);
    $display("test input type done");
    apb(1'b1, `YRW_IDX_UVFIX, 16'h4080);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `YRW_IDX_MODE, 16'h0005 | 16'(s << 12));
      frame(2, 8'h80, 8'h10, 8'h10, (s == 2) ? 0 : 40, s[1] ? 40 : 0);
      drain(1);
      `TB_CHK(fbm.data_q[0][15:0] === fbm.data_q[0][31:16], s != 0)
      clr();
    end
    $display("test chroma override done");
    apb(1'b1, `YRW_IDX_MODE, 16'h0005);
    stall <= 1'b1;
    pix_v <= 1'b1;
    sof <= 1'b1;
    n = 0;
    acc = 1'b1;
    while (acc && n < 80)
    begin
      @(posedge mclk_i);
      acc = pix_rdy;
      sof <= 1'b0;
      if (acc)
        n++;
    end
    pix_v <= 1'b0;
    apb(1'b0, `YRW_IDX_STATUS, 16'h0000);
    `TB_CHK(rd[7:3], 5'h10)
    stall <= 1'b0;
    drain(n / 2);
    clr();
    apb(1'b0, `YRW_IDX_STATUS, 16'h0000);
    `TB_CHK(rd[7:3], 5'h00)
    `TB_CHK(fbm.bad, 0)
    $display("test buffer done");
    results();
  end
endmodule
